// *** src/mie_core.sv ***
// mie_core: fetch and execute of the eight-bit instruction set
// assumes program memory answers prog_data within one instruction cycle
// and that prog_data comes from logic on clk
`timescale 1ns/1ns
`include "mie_params.svh"
module mie_core (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [`MIE_IW-1:0] prog_data,
  input wire logic wake,
  output logic [`MIE_PCW-1:0] prog_addr,
  output logic [`MIE_DW-1:0] acc,
  output logic [`MIE_NW-1:0] flags,
  output logic halted,
  output logic wdt_clear,
  output logic cycle_strobe
);
  mie_pkg::mie_phase_type phase, next_phase;
  mie_pkg::mie_state_type state, next_state;
  logic [`MIE_PCW-1:0] pc, next_pc, next_prog_addr, target, cur_pc;
  logic [`MIE_PCW-1:0] stack_top;
  logic [`MIE_IW-1:0] ir, next_ir;
  logic ir_valid, next_ir_valid;
  logic [`MIE_DW-1:0] next_acc;
  logic [`MIE_NW-1:0] next_flags;
  logic next_halted, next_wdt_clear;
  logic [`MIE_AW-1:0] tab_dest, next_tab_dest;
  logic [`MIE_SPW-1:0] sp, next_sp;
  logic [`MIE_DW-1:0] dm [`MIE_DM_DEPTH];
  logic [`MIE_PCW-1:0] stack [`MIE_STACK_DEPTH];
  logic wake_meta, wake_s;
  logic cyc_end, exec, alt, redirect, skip_hit, stk_we;
  logic dm_we;
  logic [`MIE_AW-1:0] dm_wa, maddr;
  logic [`MIE_DW-1:0] dm_wd, dm_rd, imm, alu_b;
  logic [`MIE_IDXW-1:0] idx;
  mie_pkg::mie_op_type op;

  mie_alu_if alu_bus ();
  mie_alu i_mie_alu (
    .alu(alu_bus)
  );

  // one instruction cycle is four system clocks [RL2]
  always_comb begin
    unique case (phase)
      mie_pkg::ph0: next_phase = mie_pkg::ph1;
      mie_pkg::ph1: next_phase = mie_pkg::ph2;
      mie_pkg::ph2: next_phase = mie_pkg::ph3;
      mie_pkg::ph3: next_phase = mie_pkg::ph0;
    endcase
  end

  assign cyc_end = (phase == mie_pkg::ph3);
  assign op = mie_pkg::mie_op_type'(ir[`MIE_OP_HI:`MIE_OP_LO]);
  assign alt = ir[`MIE_ALT_BIT];
  assign maddr = ir[`MIE_AW-1:0];
  assign imm = ir[`MIE_DW-1:0];
  assign idx = ir[`MIE_IDX_HI:`MIE_IDX_LO];
  assign exec = cyc_end && ir_valid && state == mie_pkg::st_run;
  assign cur_pc = pc - 1'b1;
  assign stack_top = stack[sp - 1'b1];
  // the low program counter byte reads as the executing address
  assign dm_rd = (maddr == `MIE_LOW_PC_ADDR) ? cur_pc[`MIE_DW-1:0]
               : dm[maddr];
  // second operand of logic and arithmetic may be immediate [RL9]
  assign alu_b = ((alt && op inside {mie_pkg::add_op, mie_pkg::add_carry_op,
                  mie_pkg::sub_op, mie_pkg::sub_borrow_op, mie_pkg::and_op,
                  mie_pkg::or_op, mie_pkg::xor_op})
                  || op == mie_pkg::transfer_imm_op) ? imm : dm_rd;
  assign alu_bus.op = op;
  assign alu_bus.a = acc;
  assign alu_bus.b = alu_b;
  assign alu_bus.idx = idx;
  assign alu_bus.cin = flags[`MIE_FLAG_C];

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_prog_addr = prog_addr;
    next_ir = ir;
    next_ir_valid = ir_valid;
    next_acc = acc;
    next_flags = flags;
    next_halted = halted;
    next_wdt_clear = 1'b0;
    next_tab_dest = tab_dest;
    next_sp = sp;
    dm_we = 1'b0;
    dm_wa = maddr;
    dm_wd = alu_bus.res;
    stk_we = 1'b0;
    redirect = 1'b0;
    target = pc;
    skip_hit = 1'b0;
    if (cyc_end) begin
      unique case (state)
        mie_pkg::st_halt: begin
          if (wake_s) begin
            next_state = mie_pkg::st_run;
            next_halted = 1'b0;
          end
        end
        mie_pkg::st_table: begin
          // second cycle returns the program word's low byte to data memory [RL14] [RL1]
          dm_we = 1'b1;
          dm_wa = tab_dest;
          dm_wd = prog_data[`MIE_DW-1:0];
          next_prog_addr = pc;
          next_state = mie_pkg::st_run;
        end
        mie_pkg::st_run: begin
          next_ir = prog_data;
          next_ir_valid = 1'b1;
          next_pc = pc + 1'b1;
          next_prog_addr = pc + 1'b1;
          if (ir_valid) begin
            unique case (op)
              mie_pkg::add_op, mie_pkg::add_carry_op, mie_pkg::sub_op,
              mie_pkg::sub_borrow_op: begin
                next_acc = alu_bus.res; // [RL18]
                next_flags = {alu_bus.ov, alu_bus.ac, alu_bus.c,
                              alu_bus.z}; // [RL16]
              end
              mie_pkg::and_op, mie_pkg::or_op, mie_pkg::xor_op: begin
                next_acc = alu_bus.res; // [RL9]
                next_flags[`MIE_FLAG_Z] = alu_bus.z; // [RL8]
              end
              mie_pkg::complement_op, mie_pkg::plus_one_op,
              mie_pkg::minus_one_op: begin
                // alt selects memory, else accumulator [RL7]
                dm_we = alt;
                if (!alt) begin
                  next_acc = alu_bus.res;
                end
                next_flags[`MIE_FLAG_Z] = alu_bus.z; // [RL8]
              end
              mie_pkg::rotate_right_op, mie_pkg::rotate_left_op,
              mie_pkg::rotate_right_via_carry,
              mie_pkg::rotate_left_via_carry: begin
                dm_we = alt;
                if (!alt) begin
                  next_acc = alu_bus.res;
                end
                next_flags[`MIE_FLAG_C] = alu_bus.c; // [RL10] [RL16]
              end
              mie_pkg::transfer_to_acc_op, mie_pkg::transfer_imm_op:
                next_acc = alu_bus.res; // [RL13]
              mie_pkg::transfer_to_mem_op: dm_we = 1'b1; // [RL13]
              mie_pkg::bit_set_op, mie_pkg::bit_clear_op:
                dm_we = 1'b1; // [RL11]
              mie_pkg::skip_zero_op: begin
                if (alt) begin
                  next_acc = dm_rd;
                end
                skip_hit = (dm_rd == '0); // [RL12]
              end
              mie_pkg::skip_bit_zero_op: skip_hit = !dm_rd[idx]; // [RL12]
              mie_pkg::skip_bit_set_op: skip_hit = dm_rd[idx]; // [RL12]
              mie_pkg::skip_inc_zero_op, mie_pkg::skip_minus_zero_op: begin
                dm_we = !alt;
                if (alt) begin
                  next_acc = alu_bus.res;
                end
                skip_hit = alu_bus.z; // [RL12]
              end
              mie_pkg::unconditional_jump_op: begin
                redirect = 1'b1; // [RL5]
                target = ir[`MIE_PCW-1:0];
              end
              mie_pkg::call_op: begin
                stk_we = 1'b1; // [RL5]
                next_sp = sp + 1'b1;
                redirect = 1'b1;
                target = ir[`MIE_PCW-1:0];
              end
              mie_pkg::leave_subroutine_op, mie_pkg::leave_interrupt_op:
              begin
                redirect = 1'b1; // [RL5]
                target = stack_top;
                next_sp = sp - 1'b1;
              end
              mie_pkg::table_read_op: begin
                next_tab_dest = maddr; // [RL14]
                next_prog_addr = {`MIE_TBL_PAGE, dm[`MIE_TBLP_ADDR]};
                next_state = mie_pkg::st_table;
              end
              mie_pkg::halt_op: begin
                next_state = mie_pkg::st_halt; // [RL15]
                next_halted = 1'b1;
              end
              mie_pkg::watchdog_clear_op: next_wdt_clear = 1'b1; // [RL15]
              mie_pkg::no_op: next_ir_valid = 1'b1;
            endcase
            // a taken skip drops the prefetched instruction [RL4]
            if (skip_hit) begin
              next_ir_valid = 1'b0;
            end
            // writing the low pc byte acts as a jump [RL3]
            if (dm_we && dm_wa == `MIE_LOW_PC_ADDR) begin
              redirect = 1'b1;
              target = {pc[`MIE_PCW-1:`MIE_DW], dm_wd};
            end
            // discard the prefetch and refetch at the target [RL17] [RL1]
            if (redirect) begin
              next_pc = target;
              next_prog_addr = target;
              next_ir_valid = 1'b0;
            end
          end
        end
        // unused state code falls back to running
        default: next_state = mie_pkg::st_run;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= mie_pkg::ph0;
      state <= mie_pkg::st_run;
      pc <= `MIE_PC_RST;
      prog_addr <= `MIE_PC_RST;
      ir <= '0;
      ir_valid <= 1'b0;
      acc <= `MIE_ACC_RST;
      flags <= `MIE_FLAGS_RST;
      halted <= 1'b0;
      wdt_clear <= 1'b0;
      cycle_strobe <= 1'b0;
      tab_dest <= '0;
      sp <= '0;
      wake_meta <= 1'b0;
      wake_s <= 1'b0;
    end else begin
      phase <= next_phase;
      state <= next_state;
      pc <= next_pc;
      prog_addr <= next_prog_addr;
      ir <= next_ir;
      ir_valid <= next_ir_valid;
      acc <= next_acc;
      flags <= next_flags;
      halted <= next_halted;
      wdt_clear <= next_wdt_clear;
      cycle_strobe <= (next_phase == mie_pkg::ph3);
      tab_dest <= next_tab_dest;
      sp <= next_sp;
      wake_meta <= wake;
      wake_s <= wake_meta;
    end
  end

  // storage arrays need no reset
  always_ff @(posedge clk) begin
    if (dm_we) begin
      dm[dm_wa] <= dm_wd;
    end
    if (stk_we) begin
      stack[sp] <= pc;
    end
  end

  logic [`MIE_DW:0] sum9;
  logic [`MIE_DW-1:0] inc_val;
  assign sum9 = {1'b0, acc} + {1'b0, alu_b};
  assign inc_val = dm_rd + 1'b1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  phase_period_a: assert property ( // [RL2]
    cyc_end |=> !cyc_end [*3] ##1 cyc_end)
    else $error("instruction cycle is not four clocks");
  branch_two_a: assert property ( // [RL1]
    exec && op inside {mie_pkg::unconditional_jump_op, mie_pkg::call_op,
      mie_pkg::leave_subroutine_op} |=> !ir_valid [*4] ##1 ir_valid)
    else $error("branch did not take two cycles");
  jump_target_a: assert property ( // [RL17]
    exec && op == mie_pkg::unconditional_jump_op
    |=> prog_addr == $past(ir[`MIE_PCW-1:0]))
    else $error("jump did not refetch at target");
  low_byte_a: assert property ( // [RL3]
    exec && dm_we && dm_wa == `MIE_LOW_PC_ADDR
    |=> !ir_valid && pc[`MIE_DW-1:0] == $past(dm_wd))
    else $error("low pc byte write did not redirect");
  skip_cost_a: assert property ( // [RL4]
    exec && op inside {mie_pkg::skip_bit_zero_op, mie_pkg::skip_bit_set_op}
    |=> ir_valid == !$past(skip_hit))
    else $error("skip cost wrong");
  call_return_a: assert property ( // [RL5]
    exec && op == mie_pkg::call_op |=> stack_top == $past(pc))
    else $error("call did not save next address");
  return_addr_a: assert property ( // [RL5]
    exec && op == mie_pkg::leave_subroutine_op
    |=> prog_addr == $past(stack_top))
    else $error("return went to wrong address");
  add_carry_a: assert property ( // [RL6]
    exec && op == mie_pkg::add_op
    |=> flags[`MIE_FLAG_C] == $past(sum9[`MIE_DW]))
    else $error("add carry wrong");
  step_one_a: assert property ( // [RL7]
    exec && op == mie_pkg::plus_one_op && !alt |=> acc == $past(inc_val))
    else $error("increment not by one");
  logic_zero_a: assert property ( // [RL8]
    exec && op inside {mie_pkg::and_op, mie_pkg::or_op, mie_pkg::xor_op}
    |=> flags[`MIE_FLAG_Z] == (acc == '0))
    else $error("zero flag wrong after logic op");
  bit_only_a: assert property ( // [RL11]
    exec && op == mie_pkg::bit_clear_op
    |-> dm_we && !dm_wd[idx] && $countones(dm_wd ^ dm_rd) <= 1)
    else $error("bit clear touched other bits");
  flags_kept_a: assert property ( // [RL16]
    exec && op inside {mie_pkg::transfer_to_acc_op, mie_pkg::transfer_imm_op,
      mie_pkg::rotate_right_op, mie_pkg::rotate_left_op}
    |=> $stable(flags))
    else $error("move or rotate changed flags");
  halt_enter_a: assert property ( // [RL15]
    exec && op == mie_pkg::halt_op |=> halted [*4])
    else $error("halt did not power down");
endmodule

// *** src/mie_params.svh ***
// mie_params.svh: constants of the instruction execution core
// assumes every core file includes it by bare name
// Function
// RL1: most take one cycle, branches take two
// RL2: instruction cycle is four system clocks
// RL3: low program counter byte write costs two
// RL4: skip costs one, taken skip adds one
// RL5: call saves next address, return resumes there
// RL6: carry above 255, borrow below 0
// RL7: increment and decrement change by exactly one
// RL8: logic results of zero set zero flag
// RL9: logic ops take one operand from accumulator
// RL10: rotate by one, carry variants use carry
// RL11: bit set and clear touch one bit
// RL12: conditional skips test byte or bit
// RL13: three move forms through the accumulator
// RL14: table read fetches program memory data
// RL15: halt powers down, watchdog clear exists
// RL16: add and subtract set four flags, moves none
// RL17: two-cycle ops discard prefetched instruction; table read keeps its prefetch and executes it after st_table
// RL18: eight-bit data, overflow only in flags
`ifndef MIE_PARAMS_SVH
`define MIE_PARAMS_SVH
`define MIE_DW 8
`define MIE_NW 4
`define MIE_PCW 11
`define MIE_IW 16
`define MIE_AW 6
`define MIE_DM_DEPTH 64
`define MIE_STACK_DEPTH 4
`define MIE_SPW 2
`define MIE_OP_HI 15
`define MIE_OP_LO 11
`define MIE_ALT_BIT 10
`define MIE_IDX_HI 10
`define MIE_IDX_LO 8
`define MIE_IDXW 3
`define MIE_LOW_PC_ADDR 6'h02
`define MIE_TBLP_ADDR 6'h03
`define MIE_TBL_PAGE 3'h7
`define MIE_PC_RST 11'h000
`define MIE_ACC_RST 8'h00
`define MIE_FLAGS_RST 4'h0
`define MIE_FLAG_Z 0
`define MIE_FLAG_C 1
`define MIE_FLAG_AC 2
`define MIE_FLAG_OV 3
`endif

// *** src/mie_pkg.sv ***
// mie_pkg: operation classes and state encodings of the core
// assumes nothing beyond the params header
package mie_pkg;
  typedef enum logic [4:0] {
    add_op = 5'h00, add_carry_op = 5'h01, sub_op = 5'h02,
    sub_borrow_op = 5'h03, and_op = 5'h04, or_op = 5'h05,
    xor_op = 5'h06, complement_op = 5'h07, plus_one_op = 5'h08,
    minus_one_op = 5'h09, rotate_right_op = 5'h0A,
    rotate_right_via_carry = 5'h0B, rotate_left_op = 5'h0C,
    rotate_left_via_carry = 5'h0D, transfer_to_acc_op = 5'h0E,
    transfer_to_mem_op = 5'h0F, transfer_imm_op = 5'h10,
    bit_set_op = 5'h11, bit_clear_op = 5'h12, skip_zero_op = 5'h13,
    skip_bit_zero_op = 5'h14, skip_bit_set_op = 5'h15,
    skip_inc_zero_op = 5'h16, skip_minus_zero_op = 5'h17,
    unconditional_jump_op = 5'h18, call_op = 5'h19,
    leave_subroutine_op = 5'h1A, leave_interrupt_op = 5'h1B,
    table_read_op = 5'h1C, halt_op = 5'h1D, watchdog_clear_op = 5'h1E,
    no_op = 5'h1F
  } mie_op_type;
  // gray sequence through the four system clocks of a cycle
  typedef enum logic [1:0] {
    ph0 = 2'h0, ph1 = 2'h1, ph2 = 2'h3, ph3 = 2'h2
  } mie_phase_type;
  typedef enum logic [1:0] {
    st_run = 2'h0, st_table = 2'h1, st_halt = 2'h2
  } mie_state_type;
endpackage

// *** src/mie_alu_if.sv ***
// mie_alu_if: operands and results between core and alu
// assumes the alu answers combinationally
`timescale 1ns/1ns
`include "mie_params.svh"
interface mie_alu_if;
  mie_pkg::mie_op_type op;
  logic [`MIE_DW-1:0] a;
  logic [`MIE_DW-1:0] b;
  logic [`MIE_IDXW-1:0] idx;
  logic cin;
  logic [`MIE_DW-1:0] res;
  logic c;
  logic ac;
  logic ov;
  logic z;
  modport core (output op, a, b, idx, cin, input res, c, ac, ov, z);
  modport alu (input op, a, b, idx, cin, output res, c, ac, ov, z);
endinterface

// *** src/mie_alu.sv ***
// mie_alu: eight-bit result and flags for each operation class
// assumes a holds the accumulator and b the memory or immediate operand
`timescale 1ns/1ns
`include "mie_params.svh"
module mie_alu (
  mie_alu_if.alu alu
);
  // returns {carry, half carry, overflow, sum}
  function automatic logic [`MIE_DW+2:0] mie_add(
    input logic [`MIE_DW-1:0] x,
    input logic [`MIE_DW-1:0] y,
    input logic ci
  );
    logic [`MIE_DW:0] s;
    logic [`MIE_NW:0] h;
    logic v;
    s = {1'b0, x} + {1'b0, y} + {{`MIE_DW{1'b0}}, ci};
    h = {1'b0, x[`MIE_NW-1:0]} + {1'b0, y[`MIE_NW-1:0]}
      + {{`MIE_NW{1'b0}}, ci};
    v = (x[`MIE_DW-1] == y[`MIE_DW-1]) && (s[`MIE_DW-1] != x[`MIE_DW-1]);
    return {s[`MIE_DW], h[`MIE_NW], v, s[`MIE_DW-1:0]};
  endfunction

  logic [`MIE_DW+2:0] t;
  logic [`MIE_DW-1:0] mask;

  always_comb begin
    t = '0;
    mask = `MIE_DW'(1) << alu.idx;
    alu.res = alu.b;
    alu.c = alu.cin;
    alu.ac = 1'b0;
    alu.ov = 1'b0;
    unique case (alu.op)
      mie_pkg::add_op, mie_pkg::add_carry_op: begin
        // sum truncated to eight bits, overflow only in flags [RL6] [RL18]
        t = mie_add(alu.a, alu.b, alu.op == mie_pkg::add_carry_op && alu.cin);
        {alu.c, alu.ac, alu.ov, alu.res} = t;
      end
      mie_pkg::sub_op, mie_pkg::sub_borrow_op: begin
        // carry flag holds the borrow after a subtraction [RL6]
        t = mie_add(alu.a, ~alu.b,
                    !(alu.op == mie_pkg::sub_borrow_op && alu.cin));
        {alu.c, alu.ac, alu.ov, alu.res} = {!t[`MIE_DW+2], !t[`MIE_DW+1],
                                           t[`MIE_DW:0]};
      end
      mie_pkg::and_op: alu.res = alu.a & alu.b; // [RL9]
      mie_pkg::or_op: alu.res = alu.a | alu.b; // [RL9]
      mie_pkg::xor_op: alu.res = alu.a ^ alu.b; // [RL9]
      mie_pkg::complement_op: alu.res = ~alu.b;
      mie_pkg::plus_one_op, mie_pkg::skip_inc_zero_op:
        alu.res = alu.b + 1'b1; // [RL7]
      mie_pkg::minus_one_op, mie_pkg::skip_minus_zero_op:
        alu.res = alu.b - 1'b1; // [RL7]
      mie_pkg::rotate_right_op:
        alu.res = {alu.b[0], alu.b[`MIE_DW-1:1]}; // [RL10]
      mie_pkg::rotate_left_op:
        alu.res = {alu.b[`MIE_DW-2:0], alu.b[`MIE_DW-1]}; // [RL10]
      mie_pkg::rotate_right_via_carry: begin
        alu.res = {alu.cin, alu.b[`MIE_DW-1:1]}; // [RL10]
        alu.c = alu.b[0];
      end
      mie_pkg::rotate_left_via_carry: begin
        alu.res = {alu.b[`MIE_DW-2:0], alu.cin}; // [RL10]
        alu.c = alu.b[`MIE_DW-1];
      end
      mie_pkg::transfer_to_mem_op: alu.res = alu.a; // [RL13]
      mie_pkg::bit_set_op: alu.res = alu.b | mask; // [RL11]
      mie_pkg::bit_clear_op: alu.res = alu.b & ~mask; // [RL11]
      mie_pkg::transfer_to_acc_op, mie_pkg::transfer_imm_op,
      mie_pkg::skip_zero_op, mie_pkg::skip_bit_zero_op,
      mie_pkg::skip_bit_set_op, mie_pkg::unconditional_jump_op,
      mie_pkg::call_op, mie_pkg::leave_subroutine_op,
      mie_pkg::leave_interrupt_op, mie_pkg::table_read_op,
      mie_pkg::halt_op, mie_pkg::watchdog_clear_op, mie_pkg::no_op:
        alu.res = alu.b;
    endcase
    alu.z = (alu.res == '0); // [RL8]
  end
endmodule

// *** testbench/mie_core_tb.sv ***
// mie_core_tb: self-checking bench for the instruction execution core
// assumes the design package and params header are compiled first
`timescale 1ns/1ns
`include "mie_params.svh"
module mie_core_tb;
  logic clk;
  logic rst_b;
  logic wake;
  logic halted;
  logic wdt_clear;
  logic cycle_strobe;
  logic [`MIE_IW-1:0] prog_data;
  logic [`MIE_PCW-1:0] prog_addr;
  logic [`MIE_DW-1:0] acc;
  logic [`MIE_NW-1:0] flags;
  logic [15:0] rom [0:2047];
  int n_fail;
  int checks_done;

  mie_core i_mie_core (
    .clk(clk),
    .rst_b(rst_b),
    .prog_data(prog_data),
    .wake(wake),
    .prog_addr(prog_addr),
    .acc(acc),
    .flags(flags),
    .halted(halted),
    .wdt_clear(wdt_clear),
    .cycle_strobe(cycle_strobe)
  );

  always #50 clk = ~clk;

  // program memory answers from logic on clk, well inside one cycle
  always @(posedge clk) begin
    #5 prog_data = rom[prog_addr];
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic w(input logic [10:0] a, input mie_pkg::mie_op_type op,
                   input logic [10:0] f);
    rom[a] = {op, f};
  endtask

  task automatic fresh;
    foreach (rom[i]) rom[i] = {mie_pkg::no_op, 11'h000};
    rst_b = 0;
    wake = 0;
  endtask

  // release reset; the first word is fetched at the 4th edge after it
  task automatic go;
    repeat (2) @(posedge clk);
    #5;
    chk({halted, wdt_clear, cycle_strobe, flags, acc, prog_addr}, 0);
    rst_b = 1;
    repeat (4) @(posedge clk);
  endtask

  // one instruction cycle, ending 5 ns after its execution edge
  task automatic step;
    repeat (3) @(posedge clk);
    #5;
    chk(cycle_strobe, 1);
    @(posedge clk);
    #5;
    chk(cycle_strobe, 0);
  endtask

  task automatic steps(input int n);
    repeat (n) step;
  endtask

  task automatic t_arith;
    fresh;
    w(0, mie_pkg::transfer_imm_op, 11'h4F0);
    w(1, mie_pkg::transfer_to_mem_op, 11'h010);
    w(2, mie_pkg::transfer_imm_op, 11'h420);
    w(3, mie_pkg::add_op, 11'h010);
    w(4, mie_pkg::sub_op, 11'h411);
    w(5, mie_pkg::add_op, 11'h401);
    w(6, mie_pkg::transfer_imm_op, 11'h47F);
    w(7, mie_pkg::add_op, 11'h401);
    w(8, mie_pkg::sub_borrow_op, 11'h480);
    w(9, mie_pkg::sub_op, 11'h401);
    w(10, mie_pkg::add_carry_op, 11'h400);
    w(11, mie_pkg::sub_borrow_op, 11'h400);
    go;
    step;
    chk({flags, acc}, 12'h0F0);
    steps(3);
    chk({flags, acc}, 12'h210);
    step;
    chk({flags, acc}, 12'h6FF);
    step;
    chk({flags, acc}, 12'h700);
    step;
    chk({flags, acc}, 12'h77F);
    step;
    chk({flags, acc}, 12'hC80);
    step;
    chk({flags, acc}, 12'h100);
    step;
    chk({flags, acc}, 12'h6FF);
    step;
    chk({flags, acc}, 12'h700);
    step;
    chk({flags, acc}, 12'h6FF);
  endtask

  task automatic t_logic;
    fresh;
    w(0, mie_pkg::transfer_imm_op, 11'h45A);
    w(1, mie_pkg::and_op, 11'h4A5);
    w(2, mie_pkg::transfer_imm_op, 11'h40F);
    w(3, mie_pkg::or_op, 11'h4F0);
    w(4, mie_pkg::xor_op, 11'h4FF);
    w(5, mie_pkg::transfer_to_mem_op, 11'h011);
    w(6, mie_pkg::plus_one_op, 11'h011);
    w(7, mie_pkg::minus_one_op, 11'h011);
    w(8, mie_pkg::minus_one_op, 11'h411);
    w(9, mie_pkg::complement_op, 11'h011);
    w(10, mie_pkg::transfer_imm_op, 11'h481);
    w(11, mie_pkg::transfer_to_mem_op, 11'h012);
    w(12, mie_pkg::rotate_right_via_carry, 11'h012);
    w(13, mie_pkg::transfer_to_mem_op, 11'h014);
    w(14, mie_pkg::rotate_left_via_carry, 11'h014);
    w(15, mie_pkg::rotate_right_op, 11'h012);
    w(16, mie_pkg::rotate_left_op, 11'h012);
    go;
    steps(2);
    chk({flags, acc}, 12'h100);
    steps(2);
    chk({flags, acc}, 12'h0FF);
    step;
    chk({flags, acc}, 12'h100);
    steps(2);
    chk({flags, acc}, 12'h001);
    step;
    chk({flags, acc}, 12'h0FF);
    step;
    chk({flags, acc}, 12'h0FF);
    step;
    chk({flags, acc}, 12'h100);
    steps(3);
    chk({flags, acc}, 12'h340);
    steps(2);
    chk({flags, acc}, 12'h181);
    step;
    chk({flags, acc}, 12'h1C0);
    step;
    chk({flags, acc}, 12'h103);
  endtask

  task automatic t_branch;
    fresh;
    w(0, mie_pkg::transfer_imm_op, 11'h400);
    w(1, mie_pkg::transfer_to_mem_op, 11'h013);
    w(2, mie_pkg::bit_set_op, 11'h313);
    w(3, mie_pkg::bit_set_op, 11'h713);
    w(4, mie_pkg::bit_clear_op, 11'h313);
    w(5, mie_pkg::transfer_to_acc_op, 11'h013);
    w(6, mie_pkg::skip_bit_zero_op, 11'h013);
    w(7, mie_pkg::transfer_imm_op, 11'h411);
    w(8, mie_pkg::transfer_imm_op, 11'h422);
    w(9, mie_pkg::skip_bit_set_op, 11'h013);
    w(10, mie_pkg::transfer_imm_op, 11'h433);
    w(11, mie_pkg::skip_zero_op, 11'h013);
    w(12, mie_pkg::transfer_imm_op, 11'h444);
    w(13, mie_pkg::transfer_imm_op, 11'h420);
    w(14, mie_pkg::transfer_to_mem_op, 11'h002);
    w(15, mie_pkg::transfer_imm_op, 11'h466);
    w(11'h020, mie_pkg::transfer_imm_op, 11'h455);
    go;
    steps(6);
    chk(acc, 8'h80);
    step;
    chk(acc, 8'h80);
    step;
    chk(acc, 8'h80);
    step;
    chk(acc, 8'h22);
    steps(2);
    chk(acc, 8'h33);
    steps(2);
    chk(acc, 8'h44);
    steps(2);
    chk(prog_addr, 11'h020);
    step;
    chk(acc, 8'h20);
    step;
    chk(acc, 8'h55);
  endtask

  task automatic t_flow;
    logic [10:0] pa;
    fresh;
    w(0, mie_pkg::call_op, 11'h030);
    w(11'h030, mie_pkg::transfer_imm_op, 11'h466);
    w(11'h031, mie_pkg::leave_subroutine_op, 11'h000);
    w(1, mie_pkg::transfer_imm_op, 11'h477);
    w(2, mie_pkg::call_op, 11'h040);
    w(11'h040, mie_pkg::leave_interrupt_op, 11'h000);
    w(3, mie_pkg::unconditional_jump_op, 11'h050);
    w(11'h050, mie_pkg::watchdog_clear_op, 11'h000);
    w(11'h051, mie_pkg::halt_op, 11'h000);
    w(11'h052, mie_pkg::transfer_imm_op, 11'h499);
    go;
    step;
    chk(prog_addr, 11'h030);
    steps(2);
    chk(acc, 8'h66);
    step;
    chk(prog_addr, 11'h001);
    steps(2);
    chk(acc, 8'h77);
    steps(3);
    chk(prog_addr, 11'h003);
    steps(2);
    chk(prog_addr, 11'h050);
    steps(2);
    chk(wdt_clear, 1);
    steps(2);
    chk({halted, wdt_clear, acc}, 10'h277);
    pa = prog_addr;
    step;
    chk({halted, prog_addr}, {1'b1, pa});
    wake = 1;
    steps(3);
    wake = 0;
    chk({halted, acc}, 9'h099);
  endtask

  task automatic t_table;
    fresh;
    w(0, mie_pkg::transfer_imm_op, 11'h405);
    w(1, mie_pkg::transfer_to_mem_op, 11'h003);
    w(2, mie_pkg::transfer_imm_op, 11'h400);
    w(3, mie_pkg::table_read_op, 11'h015);
    w(4, mie_pkg::transfer_to_acc_op, 11'h015);
    rom[11'h705] = 16'h12C3;
    go;
    steps(4);
    chk(prog_addr, 11'h705);
    steps(3);
    chk(acc, 8'hC3);
  endtask

  // increment skip to memory, decrement skip to both result targets
  task automatic t_skip;
    fresh;
    w(0, mie_pkg::transfer_imm_op, 11'h4FF);
    w(1, mie_pkg::transfer_to_mem_op, 11'h016);
    w(2, mie_pkg::transfer_imm_op, 11'h45A);
    w(3, mie_pkg::skip_inc_zero_op, 11'h016);
    w(4, mie_pkg::transfer_imm_op, 11'h411);
    w(5, mie_pkg::skip_minus_zero_op, 11'h416);
    w(6, mie_pkg::transfer_imm_op, 11'h422);
    w(7, mie_pkg::skip_zero_op, 11'h416);
    w(8, mie_pkg::transfer_imm_op, 11'h433);
    w(9, mie_pkg::plus_one_op, 11'h416);
    w(10, mie_pkg::skip_minus_zero_op, 11'h016);
    w(11, mie_pkg::plus_one_op, 11'h416);
    w(12, mie_pkg::plus_one_op, 11'h016);
    go;
    steps(5);
    chk(acc, 8'h5A);
    step;
    chk(acc, 8'hFF);
    step;
    chk(acc, 8'h22);
    step;
    chk(acc, 8'h00);
    steps(2);
    chk({flags, acc}, 12'h000);
    steps(3);
    chk({flags, acc}, 12'h001);
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 0;
    rst_b = 0;
    wake = 0;
    prog_data = '0;
    n_fail = 0;
    checks_done = 0;
    t_arith;
    t_logic;
    t_branch;
    t_flow;
    t_table;
    t_skip;
    tally_and_finish;
  end

  // about 100 instruction cycles are expected; allow several times that
  initial begin
    #300000;
    n_fail++;
    tally_and_finish;
  end
endmodule
